/* File: design/pmm_edge_if.sv */
`timescale 1ns/1ps
// Synchronised levels and rising-edge pulses of the four pin inputs.
interface pmm_edge_if;
  logic [3:0] level;
  logic [3:0] rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

/* File: design/pmm_measure.sv */
`timescale 1ns/1ps
// How it works
// - While locked, every settings change is ignored; only unlocked writes apply.
// - Decimal digit 0..3 sets zero to three decimal places.
// - Unit codes: 0 hour, 1 minute, 2 second, 3 hour-minute, 4 minute-second.
// - Combined units only for passing time, cycle timer and stopwatches.
// - Type 00 is channel A rate, type 01 is channel B rate.
// - Absolute ratio B/A*100, error ratio (B-A)/A*100.
// - Difference A-B, density B/(A+B)*100, sum A+B.
// - Codes 09..15 are shot speed, cycle timer, stopwatch A and B.
// - Codes 16..19 behave as channel A rate.
// - Real-time analog output only for types 00, 01, 08.
// - Deceleration ratio 0.1..999.9 divides the combined channel result.
// - Reverse open gives (A-B)/R, shorted gives (A+B)/R.
// - Display key cycles A with lamp, B with lamp, differential lamps off.
// - First sensor A edge starts cycle timing.
// - Later A edges show elapsed time and restart from zero.
// - Timing pauses while sensor B is active.
// - Reset input clears the display to zero and stops timing.
// - After power loss the timing indication restarts at zero.
// - Power-up with init key loads factory settings and clears the lock.
module pmm_measure
  import pmm_pkg::*;
(
  // Clock and reset.
  input  wire logic                clock,
  input  wire logic                nrst,
  // Pins from sensors and terminals.
  input  wire logic                sensor_a,
  input  wire logic                sensor_b,
  input  wire logic                reverse_in,
  input  wire logic                reset_in,
  // Front-panel keys and settings.
  input  wire logic                init_key,
  input  wire logic                lock_set,
  input  wire logic                lock_clear,
  input  wire logic                set_write,
  input  wire logic [1:0]          set_dp,
  input  wire logic [2:0]          set_unit,
  input  wire logic [4:0]          set_type,
  input  wire logic [13:0]         set_ratio,
  input  wire logic                disp_key,
  input  wire logic                analog_realtime_req,
  // Scaled channel rates from the rate front end.
  input  wire logic [PMM_W-1:0]    rate_a,
  input  wire logic [PMM_W-1:0]    rate_b,
  // Settings and results.
  output logic                     locked,
  output logic [1:0]               dp_pos,
  output logic [2:0]               meas_unit,
  output logic [4:0]               meas_type,
  output logic [13:0]              decel_ratio,
  output logic [2:0]               eff_unit,
  output logic [1:0]               eff_dp,
  output logic                     analog_realtime,
  output logic                     lamp_a,
  output logic                     lamp_b,
  output logic [PMM_W-1:0]         result,
  output logic                     result_neg,
  output logic                     shot_sel,
  output logic                     stopwatch_sel,
  output logic                     timing_active
);
  pmm_edge_if edges ();

  logic        init_phase;
  pmm_show_t   show;
  pmm_ct_t     ct_state;
  logic [PMM_W-1:0] ct_count;
  logic [PMM_W-1:0] ct_shown;
  logic [15:0] tick_cnt;
  logic        tick;

  // Pin synchroniser and edge detector.
  pmm_sync_edge u_sync
  (
    .clock (clock),
    .nrst  (nrst),
    .pins  ({reset_in, reverse_in, sensor_b, sensor_a}),
    .sync  (edges)
  );

  wire a_rise    = edges.rise[0];
  wire b_level   = edges.level[1];
  wire rev_short = edges.level[2];
  wire rst_rise  = edges.rise[3];
  wire rst_level = edges.level[3];

  // Folds alias codes 16..19 onto channel A rate.
  function automatic logic [4:0] pmm_fold(input logic [4:0] t);
    if (t >= PMM_TYPE_ALIAS_LO && t <= PMM_TYPE_ALIAS_HI)
      return PMM_TYPE_RATE_A;
    else
      return t;
  endfunction

  // Types that may use the combined time units.
  function automatic logic pmm_time_type(input logic [4:0] t);
    return t == PMM_TYPE_PASS || (t >= PMM_TYPE_CYCLE && t <= PMM_TYPE_SW_B);
  endfunction

  wire [4:0] type_f = pmm_fold(meas_type);
  wire       write_ok = set_write && !locked;
  wire       type_valid = set_type <= PMM_TYPE_ALIAS_HI;
  wire       ratio_ok = set_ratio >= PMM_RATIO_MIN && set_ratio <= PMM_RATIO_MAX;

  // Settings storage, loaded with factory values on power-up with init key.
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      init_phase  <= 1'b1;
      locked      <= 1'b0;
      dp_pos      <= PMM_DP_INIT;
      meas_unit   <= PMM_UNIT_INIT;
      meas_type   <= PMM_TYPE_INIT;
      decel_ratio <= PMM_RATIO_INIT;
    end
    else if (init_phase)
    begin
      init_phase <= 1'b0;
      if (init_key)
      begin
        locked      <= 1'b0;
        dp_pos      <= PMM_DP_INIT;
        meas_unit   <= PMM_UNIT_INIT;
        meas_type   <= PMM_TYPE_INIT;
        decel_ratio <= PMM_RATIO_INIT;
      end
    end
    else
    begin
      if (lock_set)
        locked <= 1'b1;
      else if (lock_clear)
        locked <= 1'b0;
      if (write_ok)
      begin
        dp_pos <= set_dp;
        if (set_unit <= PMM_UNIT_MS)
          meas_unit <= set_unit;
        if (type_valid)
          meas_type <= set_type;
        if (ratio_ok)
          decel_ratio <= set_ratio;
      end
    end
  end

  // Combined units fall back to minute or second for other types.
  wire combined = meas_unit == PMM_UNIT_HM || meas_unit == PMM_UNIT_MS;
  assign eff_unit = (combined && !pmm_time_type(type_f)) ?
                    ((meas_unit == PMM_UNIT_HM) ? PMM_UNIT_MIN : PMM_UNIT_SEC)
                    : meas_unit;
  // Decimal point is ignored under combined units.
  assign eff_dp = combined ? 2'h0 : dp_pos;

  // Real-time analog output only for A rate, B rate and passing time.
  assign analog_realtime = analog_realtime_req &&
    (type_f == PMM_TYPE_RATE_A || type_f == PMM_TYPE_RATE_B ||
     type_f == PMM_TYPE_PASS);

  assign shot_sel = type_f >= PMM_TYPE_SHOT_LO &&
                    type_f <= PMM_TYPE_SHOT_HI;
  assign stopwatch_sel = type_f == PMM_TYPE_SW_A ||
                         type_f == PMM_TYPE_SW_B;

  // Arithmetic forms of the selected type.
  wire [PMM_W+7:0] b_x100 = rate_b * PMM_HUNDRED;
  wire [PMM_W:0]   a_plus_b = {1'b0, rate_a} + {1'b0, rate_b};
  wire             b_ge_a = rate_b >= rate_a;
  wire [PMM_W-1:0] b_min_a = b_ge_a ? rate_b - rate_a : rate_a - rate_b;
  wire [PMM_W+7:0] bma_x100 = b_min_a * PMM_HUNDRED;
  wire [PMM_W+7:0] abs_q = (rate_a == '0) ? '0 : b_x100 / rate_a;
  wire [PMM_W+7:0] err_q = (rate_a == '0) ? '0 : bma_x100 / rate_a;
  wire [PMM_W+7:0] dens_q = (a_plus_b == '0) ? '0 :
                            b_x100 / a_plus_b;
  // Combined channel term scaled by ten because the ratio is in tenths.
  wire [PMM_W:0]   comb = rev_short ? a_plus_b :
                          {1'b0, b_ge_a ? rate_b - rate_a : rate_a - rate_b};
  wire [PMM_W+4:0] comb_x10 = comb * PMM_TEN;
  wire [PMM_W+4:0] drate_q = comb_x10 / decel_ratio;
  wire             drate_neg = !rev_short && b_ge_a && rate_b != rate_a;

  // Display-key sequence during differential-rate measurement.
  always_ff @(posedge clock)
  begin
    if (!nrst || type_f != PMM_TYPE_DRATE)
      show <= PMM_SHOW_DIFF;
    else if (disp_key)
    begin
      case (show)
        PMM_SHOW_DIFF: show <= PMM_SHOW_A;
        PMM_SHOW_A:    show <= PMM_SHOW_B;
        default:       show <= PMM_SHOW_DIFF;
      endcase
    end
  end
  assign lamp_a = show == PMM_SHOW_A;
  assign lamp_b = show == PMM_SHOW_B;

  // Millisecond tick for the cycle timer.
  assign tick = tick_cnt == 16'(PMM_TICK_CYC - 1);
  always_ff @(posedge clock)
  begin
    if (!nrst || tick)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end

  wire ct_mode = type_f == PMM_TYPE_CYCLE;

  // Cycle timer: A starts and laps, B pauses, reset clears and stops.
  always_ff @(posedge clock)
  begin
    if (!nrst || !ct_mode)
    begin
      ct_state <= PMM_CT_IDLE;
      ct_count <= '0;
      ct_shown <= '0;
    end
    else if (rst_rise || rst_level)
    begin
      ct_state <= PMM_CT_IDLE;
      ct_count <= '0;
      ct_shown <= '0;
    end
    else
    begin
      case (ct_state)
        PMM_CT_IDLE:
          if (a_rise)
          begin
            ct_state <= PMM_CT_RUN;
            ct_count <= '0;
          end
        default:
          if (a_rise)
          begin
            ct_shown <= ct_count;
            ct_count <= '0;
          end
          else if (tick && !b_level)
            ct_count <= ct_count + 1'b1;
      endcase
    end
  end
  assign timing_active = ct_state == PMM_CT_RUN;

  // Result selection per measuring type.
  logic [PMM_W-1:0] next_result;
  logic             next_neg;
  always_comb
  begin
    next_result = '0;
    next_neg    = 1'b0;
    case (type_f)
      PMM_TYPE_RATE_A: next_result = rate_a;
      PMM_TYPE_RATE_B: next_result = rate_b;
      PMM_TYPE_ABS:    next_result = abs_q[PMM_W-1:0];
      PMM_TYPE_ERR:
      begin
        next_result = err_q[PMM_W-1:0];
        next_neg    = !b_ge_a;
      end
      PMM_TYPE_DIFF:
      begin
        next_result = b_min_a;
        next_neg    = rate_b > rate_a;
      end
      PMM_TYPE_DENS:   next_result = dens_q[PMM_W-1:0];
      PMM_TYPE_SUM:    next_result = a_plus_b[PMM_W-1:0];
      PMM_TYPE_DRATE:
        if (show == PMM_SHOW_A)
          next_result = rate_a;
        else if (show == PMM_SHOW_B)
          next_result = rate_b;
        else
        begin
          next_result = drate_q[PMM_W-1:0];
          next_neg    = drate_neg;
        end
      PMM_TYPE_CYCLE:  next_result = ct_shown;
      default:         next_result = '0;
    endcase
  end

  // Result register.
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      result     <= '0;
      result_neg <= 1'b0;
    end
    else
    begin
      result     <= next_result;
      result_neg <= next_neg;
    end
  end

  a_lock_holds: assert property (@(posedge clock) disable iff (!nrst)
    (locked && !init_phase && !lock_clear) |=> $stable(meas_type))
    else $error("settings changed while locked");
  a_unit_fold: assert property (@(posedge clock) disable iff (!nrst)
    !pmm_time_type(type_f) |-> eff_unit <= PMM_UNIT_SEC)
    else $error("combined unit used by wrong type");
  a_analog_gate: assert property (@(posedge clock) disable iff (!nrst)
    analog_realtime |-> (type_f == PMM_TYPE_RATE_A ||
      type_f == PMM_TYPE_RATE_B || type_f == PMM_TYPE_PASS))
    else $error("real-time analog in wrong type");
  a_rate_a_out: assert property (@(posedge clock) disable iff (!nrst)
    (type_f == PMM_TYPE_RATE_A && meas_type >= PMM_TYPE_ALIAS_LO)
      |=> result == $past(rate_a))
    else $error("alias type not behaving as A rate");
  a_key_cycle: assert property (@(posedge clock) disable iff (!nrst)
    (type_f == PMM_TYPE_DRATE && $stable(type_f) && disp_key && lamp_a)
      |=> lamp_b && !lamp_a)
    else $error("display key sequence wrong");
  sequence s_ct_lap;
    ct_mode && timing_active && a_rise && !rst_level;
  endsequence
  a_ct_lap: assert property (@(posedge clock) disable iff (!nrst)
    s_ct_lap ##1 ct_mode |-> ct_count == '0)
    else $error("cycle timer not restarted on lap");
  a_ct_pause: assert property (@(posedge clock) disable iff (!nrst)
    (ct_mode && timing_active && b_level && !a_rise && !rst_level)
      ##1 ct_mode |-> $stable(ct_count))
    else $error("timer ran while B active");
  a_ct_reset: assert property (@(posedge clock) disable iff (!nrst)
    (ct_mode && rst_level) ##1 ct_mode |-> !timing_active && ct_shown == '0)
    else $error("reset did not clear timer");
endmodule

/* File: design/pmm_pkg.sv */
package pmm_pkg;
  // Measuring-type codes.
  localparam logic [4:0] PMM_TYPE_RATE_A   = 5'h00;
  localparam logic [4:0] PMM_TYPE_RATE_B   = 5'h01;
  localparam logic [4:0] PMM_TYPE_ABS      = 5'h02;
  localparam logic [4:0] PMM_TYPE_ERR      = 5'h03;
  localparam logic [4:0] PMM_TYPE_DIFF     = 5'h04;
  localparam logic [4:0] PMM_TYPE_DENS     = 5'h05;
  localparam logic [4:0] PMM_TYPE_SUM      = 5'h06;
  localparam logic [4:0] PMM_TYPE_DRATE    = 5'h07;
  localparam logic [4:0] PMM_TYPE_PASS     = 5'h08;
  localparam logic [4:0] PMM_TYPE_SHOT_LO  = 5'h09;
  localparam logic [4:0] PMM_TYPE_SHOT_HI  = 5'h0c;
  localparam logic [4:0] PMM_TYPE_CYCLE    = 5'h0d;
  localparam logic [4:0] PMM_TYPE_SW_A     = 5'h0e;
  localparam logic [4:0] PMM_TYPE_SW_B     = 5'h0f;
  localparam logic [4:0] PMM_TYPE_ALIAS_LO = 5'h10;
  localparam logic [4:0] PMM_TYPE_ALIAS_HI = 5'h13;

  // Measuring units.
  localparam logic [2:0] PMM_UNIT_HOUR   = 3'h0;
  localparam logic [2:0] PMM_UNIT_MIN    = 3'h1;
  localparam logic [2:0] PMM_UNIT_SEC    = 3'h2;
  localparam logic [2:0] PMM_UNIT_HM     = 3'h3;
  localparam logic [2:0] PMM_UNIT_MS     = 3'h4;

  // Factory values.
  localparam logic [1:0] PMM_DP_INIT    = 2'h2;
  localparam logic [2:0] PMM_UNIT_INIT  = 3'h1;
  localparam logic [4:0] PMM_TYPE_INIT  = 5'h00;
  localparam logic [13:0] PMM_RATIO_INIT = 14'h000a;

  // Deceleration ratio in tenths: 0.1 .. 999.9.
  localparam logic [13:0] PMM_RATIO_MIN = 14'h0001;
  localparam logic [13:0] PMM_RATIO_MAX = 14'h270f;

  localparam int unsigned PMM_W = 24;
  localparam logic [6:0] PMM_HUNDRED = 7'h64;
  localparam logic [4:0] PMM_TEN     = 5'h0a;

  // Timer tick: 1 ms at 50 MHz.
  localparam int unsigned PMM_CLK_HZ  = 50000000;
  localparam int unsigned PMM_TICK_US = 1000;
  localparam int unsigned PMM_TICK_CYC = PMM_CLK_HZ / 1000000 * PMM_TICK_US;

  // Display source during differential-rate measurement.
  typedef enum logic [1:0] {
    PMM_SHOW_DIFF = 2'b00,
    PMM_SHOW_A    = 2'b01,
    PMM_SHOW_B    = 2'b10
  } pmm_show_t;

  // Cycle-timer states.
  typedef enum logic [1:0] {
    PMM_CT_IDLE  = 2'b00,
    PMM_CT_RUN   = 2'b01
  } pmm_ct_t;
endpackage

/* File: design/pmm_sync_edge.sv */
`timescale 1ns/1ps
module pmm_sync_edge
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       nrst,
  // Raw pins: bit 0 sensor A, 1 sensor B, 2 reverse, 3 reset.
  input  wire logic [3:0] pins,
  // Synchronised view.
  pmm_edge_if.src         sync
);
  logic [3:0] stage1;
  logic [3:0] stage2;
  logic [3:0] prev;

  // Two flip-flops per pin, then one more for edge detection.
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      stage1 <= 4'h0;
      stage2 <= 4'h0;
      prev   <= 4'h0;
    end
    else
    begin
      stage1 <= pins;
      stage2 <= stage1;
      prev   <= stage2;
    end
  end

  // Only the second stage and its delay feed logic.
  assign sync.level = stage2;
  assign sync.rise  = stage2 & ~prev;

  a_edge_single: assert property (@(posedge clock) disable iff (!nrst)
    sync.rise[0] |=> !sync.rise[0])
    else $error("edge pulse longer than one cycle");
endmodule

/* File: dv/pmm_pin_model.sv */
`timescale 1ns/1ps
// Sensor heads and terminal contacts that drive the four pin inputs.
module pmm_pin_model
#(
  parameter int SKEW_NS = 0
)
(
  // Levels that the bench asks of the far side.
  input  wire logic [3:0] want,
  // Pins: sensor A, sensor B, reverse contact, reset contact.
  output logic            sensor_a,
  output logic            sensor_b,
  output logic            reverse_in,
  output logic            reset_in
);
  // Pins move a skew after the request, off the clock, like real contacts.
  always @(want)
  begin
    {reset_in, reverse_in, sensor_b, sensor_a} <= #(SKEW_NS) want;
  end
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import pmm_pkg::*;
  logic clock, nrst, init_key, lock_set, lock_clear, set_write, disp_key;
  logic analog_realtime_req, sensor_a, sensor_b, reverse_in, reset_in;
  logic [1:0] set_dp, dp_pos, eff_dp;
  logic [2:0] set_unit, meas_unit, eff_unit;
  logic [4:0] set_type, meas_type;
  logic [13:0] set_ratio, decel_ratio;
  logic [PMM_W-1:0] rate_a, rate_b, result;
  logic [3:0] want;
  logic locked, analog_realtime, lamp_a, lamp_b, result_neg, shot_sel;
  logic stopwatch_sel, timing_active;
  int n_fail, checked, seed;
  logic [13:0] r;
  logic [4:0] tl [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
                          5'h06, 5'h07, 5'h10, 5'h11, 5'h12, 5'h13};
  logic [13:0] r_lims [2] = '{PMM_RATIO_MIN, PMM_RATIO_MAX};

  pmm_pin_model #(.SKEW_NS(7)) partner (.want(want), .sensor_a(sensor_a),
    .sensor_b(sensor_b), .reverse_in(reverse_in), .reset_in(reset_in));

  pmm_measure DUT (.clock(clock), .nrst(nrst), .sensor_a(sensor_a),
    .sensor_b(sensor_b), .reverse_in(reverse_in), .reset_in(reset_in),
    .init_key(init_key), .lock_set(lock_set), .lock_clear(lock_clear),
    .set_write(set_write), .set_dp(set_dp), .set_unit(set_unit),
    .set_type(set_type), .set_ratio(set_ratio), .disp_key(disp_key),
    .analog_realtime_req(analog_realtime_req), .rate_a(rate_a),
    .rate_b(rate_b), .locked(locked), .dp_pos(dp_pos),
    .meas_unit(meas_unit), .meas_type(meas_type),
    .decel_ratio(decel_ratio), .eff_unit(eff_unit), .eff_dp(eff_dp),
    .analog_realtime(analog_realtime), .lamp_a(lamp_a), .lamp_b(lamp_b),
    .result(result), .result_neg(result_neg), .shot_sel(shot_sel),
    .stopwatch_sel(stopwatch_sel), .timing_active(timing_active));

  // Clock of 20 ns period.
  always #10 clock = ~clock;

  // Compares one value and counts the outcome.
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
      n_fail++;
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // One settings write, held for one edge.
  task automatic wr(logic [1:0] d, logic [2:0] u, logic [4:0] t,
                    logic [13:0] q);
    @(posedge clock);
    set_write <= 1'b1;
    set_dp <= d;
    set_unit <= u;
    set_type <= t;
    set_ratio <= q;
    @(posedge clock);
    set_write <= 1'b0;
    tick(1);
  endtask

  // Pulses one key for one edge: 0 lock set, 1 lock clear, else display.
  task automatic pulse_key(int k);
    @(posedge clock);
    case (k)
      0: lock_set <= 1'b1;
      1: lock_clear <= 1'b1;
      default: disp_key <= 1'b1;
    endcase
    @(posedge clock);
    lock_set <= 1'b0;
    lock_clear <= 1'b0;
    disp_key <= 1'b0;
    tick(2);
  endtask

  // Expected {sign, magnitude} of the selected computation.
  function automatic logic [24:0] calc(logic [4:0] t, longint a, longint b,
                                       longint q, logic rv);
    longint m;
    logic n;
    n = 1'b0;
    case (t)
      5'h01: m = b;
      5'h02: m = (a == 0) ? 0 : b * 100 / a;
      5'h03:
      begin
        n = b < a;
        m = (a == 0) ? 0 : (n ? a - b : b - a) * 100 / a;
      end
      5'h04:
      begin
        n = b > a;
        m = n ? b - a : a - b;
      end
      5'h05: m = (a + b == 0) ? 0 : b * 100 / (a + b);
      5'h06: m = a + b;
      5'h07:
      begin
        n = !rv && a < b;
        m = (rv ? a + b : (n ? b - a : a - b)) * 10 / q;
      end
      default: m = a;
    endcase
    return {n, m[23:0]};
  endfunction

  // Random rates on a type; result follows one edge after the rates.
  // The ratio expected is r, the last ratio that the bench wrote.
  task automatic rates(logic [4:0] t, logic rv);
    logic [23:0] a, b;
    a = ($random(seed) & 24'h00ffff) + 24'h1;
    b = ($random(seed) & 24'h00ffff) + 24'h1;
    @(posedge clock);
    rate_a <= a;
    rate_b <= b;
    tick(3);
    check("result", {result_neg, result}, calc(t, a, b, r, rv));
  endtask

  initial
  begin
    repeat (90000) @(posedge clock);
    n_fail++;
    test_done();
  end

  initial
  begin
    clock = 0; nrst = 0; init_key = 0; lock_set = 0; lock_clear = 0;
    set_write = 0; set_dp = 0; set_unit = 0; set_type = 0; set_ratio = 0;
    disp_key = 0; analog_realtime_req = 0; rate_a = 0; rate_b = 0;
    want = 0; n_fail = 0; checked = 0; seed = 23073;
    tick(3);
    nrst <= 1'b1;
    tick(2);
    // Lock refuses writes, unlock lets them in.
    pulse_key(0);
    wr(2'h3, 3'h2, 5'h06, 14'h0014);
    check("locked", locked, 1);
    check("type", meas_type, 0);
    pulse_key(1);
    wr(2'h3, 3'h2, 5'h06, 14'h0014);
    check("type", meas_type, 6);
    // Out-of-range unit, type and ratio, sent together in one write, are all refused.
    wr(2'h0, 3'h5, 5'h14, 14'h0000);
    check("unit", meas_unit, 2);
    check("type", meas_type, 6);
    check("ratio", decel_ratio, 14'h0014);
    for (int d = 0; d < 4; d++)
    begin
      wr(d[1:0], 3'h2, 5'h00, 14'h000a);
      check("eff_dp", eff_dp, d);
    end
    for (int u = 3; u < 5; u++)
    begin
      wr(2'h1, u[2:0], 5'h00, 14'h000a);
      check("eff_unit", eff_unit, u - 2);
      wr(2'h1, u[2:0], 5'h0d, 14'h000a);
      check("eff_unit", eff_unit, u);
    end
    // Every type code 0..19 checks shot, stopwatch and analog selection.
    analog_realtime_req <= 1'b1;
    for (int t = 0; t < 20; t++)
    begin
      wr(2'h2, 3'h1, t[4:0], 14'h000a);
      check("type", meas_type, t);
      check("shot", shot_sel, t >= 9 && t <= 12);
      check("stopwatch", stopwatch_sel, t == 14 || t == 15);
      check("analog", analog_realtime, t < 2 || t == 8 || t >= 16);
    end
    foreach (tl[i])
    begin
      r = (tl[i] == 5'h07) ? 14'h000a : 14'h0001 + ($random(seed) & 14'h0fff);
      wr(2'h2, 3'h1, tl[i], r);
      repeat (3) rates(tl[i], 1'b0);
    end
    // Reverse contact shorted; ratio at both limits.
    want <= 4'b0100;
    foreach (r_lims[i])
    begin
      r = r_lims[i];
      wr(2'h2, 3'h1, 5'h07, r);
      tick(6);
      rates(5'h07, 1'b1);
    end
    want <= 4'b0000;
    tick(6);
    rates(5'h07, 1'b0);
    // Display key steps A, B, then back to the differential rate.
    pulse_key(2);
    check("lamps", {lamp_a, lamp_b, result}, {2'b10, rate_a});
    pulse_key(2);
    check("lamps", {lamp_a, lamp_b, result}, {2'b01, rate_b});
    pulse_key(2);
    check("lamps", {lamp_a, lamp_b}, 2'b00);
    // Cycle timer: start, pause on B, lap of about 1.1 ms, then reset.
    wr(2'h2, 3'h2, 5'h0d, 14'h000a);
    want <= 4'b0001;
    tick(10);
    check("timing", timing_active, 1);
    want <= 4'b0010;
    tick(20);
    want <= 4'b0000;
    tick(55000);
    want <= 4'b0001;
    tick(10);
    check("lap", result == 1 || result == 2, 1);
    check("timing", timing_active, 1);
    want <= 4'b1000;
    tick(10);
    check("cleared", {timing_active, result}, 0);
    want <= 4'b0000;
    // Power-up with the init key held restores factory values.
    pulse_key(0);
    // A running timer is lost when power goes away.
    want <= 4'b0001;
    tick(10);
    check("timing", timing_active, 1);
    want <= 4'b0000;
    nrst <= 1'b0;
    init_key <= 1'b1;
    tick(3);
    check("power loss", {timing_active, result}, 0);
    nrst <= 1'b1;
    tick(2);
    init_key <= 1'b0;
    check("init", {locked, dp_pos, meas_unit, meas_type, decel_ratio},
          {1'b0, PMM_DP_INIT, PMM_UNIT_INIT, PMM_TYPE_INIT,
           PMM_RATIO_INIT});
    check("result", {timing_active, result}, {1'b0, rate_a});
    test_done();
  end
endmodule
